// [rtu_frame_pkg.sv]
// Purpose: Shared constants for the serial slave frame handler.
// Assumes: 50 MHz system clock, 11-bit characters on the line.
// Notes:   Byte offsets count from the address byte of a frame.
package rtu_frame_pkg;

    // ==========================================================
    // Timing
    localparam int     CLOCK_HZ           = 50_000_000;
    localparam int     BAUD_DEF           = 9600;
    localparam int     CHAR_BITS          = 11;
    // Silence in tenths of a character: 3.5 characters
    localparam int     SILENCE_TENTHS     = 35;
    // Least time, so rounded up
    localparam longint SILENCE_CYCLES_DEF =
        (longint'(CLOCK_HZ) * CHAR_BITS * SILENCE_TENTHS + BAUD_DEF * 10 - 1) / (BAUD_DEF * 10);
    localparam int     DELAY_UNIT_US      = 1000;
    localparam int     MS_CYCLES_DEF      = CLOCK_HZ / 1_000_000 * DELAY_UNIT_US;

    // ==========================================================
    // Check value
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    // ==========================================================
    // Codes
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    localparam logic [7:0] FN_READ        = 8'h03;
    localparam logic [7:0] FN_WRITE_ONE   = 8'h06;
    localparam logic [7:0] FN_ECHO        = 8'h08;
    localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FN_ERROR_FLAG  = 8'h80;
    localparam logic [7:0] ERR_FUNCTION   = 8'h01;
    localparam logic [7:0] ERR_ADDRESS    = 8'h02;
    localparam logic [7:0] ERR_DATA       = 8'h03;

    // ==========================================================
    // Frame layout and limits
    localparam int FRAME_DEPTH  = 264;
    localparam int READ_MAX     = 80;
    localparam int WRITE_MAX    = 127;
    localparam int OFS_ADDR     = 0;
    localparam int OFS_FUNC     = 1;
    localparam int OFS_START    = 2;
    localparam int OFS_COUNT    = 4;
    localparam int OFS_BYTES    = 6;
    localparam int OFS_REPLY    = 2;
    localparam int OFS_WDATA_1  = 4;
    localparam int OFS_WDATA_N  = 7;
    localparam int OFS_RDATA    = 3;
    localparam int CRC_LEN      = 2;
    localparam int LEN_MIN      = 4;
    localparam int LEN_FIXED    = 8;
    localparam int LEN_MULTI    = 9;
    localparam int REPLY_ERR    = 3;
    localparam int REPLY_WRITE  = 6;

    typedef enum logic [2:0] {
        ST_RX    = 3'b000,
        ST_CHECK = 3'b001,
        ST_EXEC  = 3'b010,
        ST_DELAY = 3'b011,
        ST_SEND  = 3'b100
    } state_e;

endpackage

// [crc16_byte_step.sv]
// Purpose: One byte step of the 16-bit frame check value.
// Assumes: Caller holds the running value in its own register.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module crc16_byte_step (
    input  wire logic [15:0] i_crc,
    input  wire logic [7:0]  i_data,
    output logic      [15:0] o_crc
);

    always_comb begin
        o_crc = i_crc ^ {8'h00, i_data};
        for (int b = 0; b < 8; b++) begin
            if (o_crc[0]) begin
                o_crc = (o_crc >> 1) ^ rtu_frame_pkg::CRC_POLY;
            end else begin
                o_crc = o_crc >> 1;
            end
        end
    end

endmodule

// [rtu_slave_frame_handler.sv]
// Purpose: Slave frame handler: framing, address match, check value,
//          function decode, reply build and send.
// Assumes: Byte UART outside; variable service answers one cycle after a strobe.
// Notes:   The frame buffer is reused in place to build the reply.
//
// Overview of operation
// - Frames are bounded by at least 3.5 character times of line silence.
// - Address zero is broadcast: executed, never answered.
// - Second byte is the one-byte function code.
// - Two check bytes cover address byte through last data byte.
// - Check register starts at all ones.
// - Each byte is XORed into the low eight check bits first.
// - Eight right shifts per byte, XOR A001 when a one drops out.
// - Reply address equals the received unit number.
// - Normal reply echoes function; error reply adds 80 hex.
// - Error reply carries one cause byte, then the check bytes.
// - Foreign nonzero address: discard silently.
// - Parity, framing or overrun fault on any character: drop, no reply.
// - Check mismatch: no execution, no reply.
// - Gap over 3.5 characters mid-frame abandons it silently.
// - Functions 03 multiple read and 10 multiple write supported.
// - Functions 06 single write and 08 echo supported.
// - Only the two write functions execute under broadcast.
// - Element counts are two-byte fields.
// - Each value is a two-byte integer.
// - Read reply carries byte count before the data.
// - Error causes: 01 function, 02 address, 03 length or count.
// - Reply waits a 0..127 ms send delay before going out.
`timescale 1ns/1ps
module rtu_slave_frame_handler #(
    parameter int SILENCE_CYCLES = int'(rtu_frame_pkg::SILENCE_CYCLES_DEF),
    parameter int MS_CYCLES      = rtu_frame_pkg::MS_CYCLES_DEF,
    parameter int DEPTH          = rtu_frame_pkg::FRAME_DEPTH
) (
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic [5:0]  i_unit_number,
    input  wire logic [6:0]  i_send_delay_ms,
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_error,
    input  wire logic        i_tx_ready,
    input  wire logic [15:0] i_rd_data,
    input  wire logic [7:0]  i_rd_error,
    input  wire logic [7:0]  i_wr_error,
    output logic             o_tx_valid,
    output logic      [7:0]  o_tx_data,
    output logic             o_rd_strobe,
    output logic             o_wr_strobe,
    output logic      [15:0] o_var_addr,
    output logic      [15:0] o_wr_data
);

    localparam int IW = $clog2(DEPTH + 1);
    localparam int SW = $clog2(SILENCE_CYCLES + 1);
    localparam int MW = $clog2(MS_CYCLES + 1);

    rtu_frame_pkg::state_e state;
    logic [7:0]    mem [DEPTH];
    logic [IW-1:0] rx_len;
    logic          rx_bad;
    logic [SW-1:0] silence_cnt;
    logic          frame_end;
    logic [15:0]   crc;
    logic [15:0]   next_crc;
    logic [15:0]   crc_seed;
    logic [7:0]    crc_byte;
    logic [IW-1:0] idx;
    logic [IW-1:0] elem;
    logic [IW-1:0] reply_len;
    logic [IW-1:0] data_ofs;
    logic [1:0]    phase;
    logic [15:0]   start_addr;
    logic          is_read;
    logic          frame_bc;
    logic [MW-1:0] ms_cnt;
    logic [6:0]    ms_left;

    // ==========================================================
    // Frame decode
    int          frame_len;
    int          count_i;
    int          bytes_i;
    logic [7:0]  func;
    logic        bcast;
    logic        drop;
    logic [7:0]  chk_err;
    logic [7:0]  svc_err;
    logic        tx_fire;
    logic        last_elem;

    always_comb begin
        frame_len = int'(rx_len);
        count_i   = int'({mem[rtu_frame_pkg::OFS_COUNT], mem[rtu_frame_pkg::OFS_COUNT+1]});
        bytes_i   = int'(mem[rtu_frame_pkg::OFS_BYTES]);
        func      = mem[rtu_frame_pkg::OFS_FUNC];
        bcast     = mem[rtu_frame_pkg::OFS_ADDR] == rtu_frame_pkg::ADDR_BROADCAST;
        drop      = rx_bad
                 || frame_len < rtu_frame_pkg::LEN_MIN
                 || crc != 16'h0000
                 || (!bcast && mem[rtu_frame_pkg::OFS_ADDR] != {2'b00, i_unit_number})
                 || (bcast && func != rtu_frame_pkg::FN_WRITE_ONE
                           && func != rtu_frame_pkg::FN_WRITE_MULTI);
        chk_err   = 8'h00;
        case (func)
            rtu_frame_pkg::FN_READ: begin
                if (frame_len != rtu_frame_pkg::LEN_FIXED || count_i == 0
                        || count_i > rtu_frame_pkg::READ_MAX) begin
                    chk_err = rtu_frame_pkg::ERR_DATA;
                end
            end
            rtu_frame_pkg::FN_WRITE_MULTI: begin
                if (frame_len < rtu_frame_pkg::LEN_MULTI || count_i == 0
                        || count_i > rtu_frame_pkg::WRITE_MAX || bytes_i != 2 * count_i
                        || frame_len != rtu_frame_pkg::LEN_MULTI + bytes_i) begin
                    chk_err = rtu_frame_pkg::ERR_DATA;
                end
            end
            rtu_frame_pkg::FN_WRITE_ONE: begin
                if (frame_len != rtu_frame_pkg::LEN_FIXED) begin
                    chk_err = rtu_frame_pkg::ERR_DATA;
                end
            end
            rtu_frame_pkg::FN_ECHO: chk_err = 8'h00;
            default: chk_err = rtu_frame_pkg::ERR_FUNCTION;
        endcase
        svc_err   = is_read ? i_rd_error : i_wr_error;
        tx_fire   = o_tx_valid && i_tx_ready;
        last_elem = idx == elem - 1'b1;
    end

    // ==========================================================
    // Silence timing; ends a frame on both a clean end and a long gap
    always_ff @(posedge i_clock) begin
        if (i_srst || i_rx_valid || state == rtu_frame_pkg::ST_SEND) begin
            silence_cnt <= '0;
        end else if (silence_cnt != SW'(SILENCE_CYCLES)) begin
            silence_cnt <= silence_cnt + 1'b1;
        end
    end

    assign frame_end = state == rtu_frame_pkg::ST_RX && rx_len != '0 && !i_rx_valid
                    && silence_cnt == SW'(SILENCE_CYCLES - 1);

    // ==========================================================
    // Receive collection
    always_ff @(posedge i_clock) begin
        if (i_srst || state != rtu_frame_pkg::ST_RX) begin
            rx_len <= '0;
            rx_bad <= 1'b0;
        end else if (i_rx_valid) begin
            // A byte with no silence before it cannot open a frame
            if (rx_len == '0 && silence_cnt != SW'(SILENCE_CYCLES)) begin
                rx_bad <= 1'b1;
            end
            if (i_rx_error || rx_len == IW'(DEPTH)) begin
                rx_bad <= 1'b1;
            end
            if (rx_len != IW'(DEPTH)) begin
                rx_len <= rx_len + 1'b1;
            end
        end
    end

    // ==========================================================
    // Check value; residue over data plus check bytes is zero when good
    assign crc_seed = (state == rtu_frame_pkg::ST_RX && rx_len == '0) ? rtu_frame_pkg::CRC_INIT : crc;
    assign crc_byte = state == rtu_frame_pkg::ST_RX ? i_rx_data : o_tx_data;

    crc16_byte_step u_crc (
        .i_crc  (crc_seed),
        .i_data (crc_byte),
        .o_crc  (next_crc)
    );

    always_ff @(posedge i_clock) begin
        if (i_srst || state == rtu_frame_pkg::ST_DELAY) begin
            crc <= rtu_frame_pkg::CRC_INIT;
        end else if (state == rtu_frame_pkg::ST_RX && i_rx_valid) begin
            crc <= next_crc;
        end else if (tx_fire && idx < reply_len) begin
            crc <= next_crc;
        end
    end

    // ==========================================================
    // Frame buffer, also the reply under construction
    always_ff @(posedge i_clock) begin
        if (state == rtu_frame_pkg::ST_RX && i_rx_valid && rx_len != IW'(DEPTH)) begin
            mem[rx_len] <= i_rx_data;
        end else if (state == rtu_frame_pkg::ST_CHECK && !drop) begin
            if (chk_err != 8'h00) begin
                mem[rtu_frame_pkg::OFS_FUNC]  <= func | rtu_frame_pkg::FN_ERROR_FLAG;
                mem[rtu_frame_pkg::OFS_REPLY] <= chk_err;
            end else if (func == rtu_frame_pkg::FN_READ) begin
                mem[rtu_frame_pkg::OFS_REPLY] <= 8'(2 * count_i);
            end
        end else if (state == rtu_frame_pkg::ST_EXEC && phase == 2'd2) begin
            if (svc_err != 8'h00) begin
                mem[rtu_frame_pkg::OFS_FUNC]  <= func | rtu_frame_pkg::FN_ERROR_FLAG;
                mem[rtu_frame_pkg::OFS_REPLY] <= svc_err;
            end else if (is_read) begin
                mem[IW'(rtu_frame_pkg::OFS_RDATA) + {idx[IW-2:0], 1'b0}]        <= i_rd_data[15:8];
                mem[IW'(rtu_frame_pkg::OFS_RDATA) + {idx[IW-2:0], 1'b0} + 1'b1] <= i_rd_data[7:0];
            end
        end
    end

    // ==========================================================
    // Send delay in whole milliseconds
    always_ff @(posedge i_clock) begin
        if (i_srst || state != rtu_frame_pkg::ST_DELAY) begin
            ms_cnt  <= '0;
            ms_left <= i_srst ? 7'h00 : i_send_delay_ms;
        end else if (ms_left != 7'h00) begin
            if (ms_cnt == MW'(MS_CYCLES - 1)) begin
                ms_cnt  <= '0;
                ms_left <= ms_left - 1'b1;
            end else begin
                ms_cnt <= ms_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state       <= rtu_frame_pkg::ST_RX;
            idx         <= '0;
            elem        <= '0;
            reply_len   <= '0;
            data_ofs    <= '0;
            phase       <= 2'd0;
            start_addr  <= 16'h0000;
            is_read     <= 1'b0;
            frame_bc    <= 1'b0;
            o_tx_valid  <= 1'b0;
            o_tx_data   <= 8'h00;
            o_rd_strobe <= 1'b0;
            o_wr_strobe <= 1'b0;
            o_var_addr  <= 16'h0000;
            o_wr_data   <= 16'h0000;
        end else begin
            case (state)
                rtu_frame_pkg::ST_RX: begin
                    if (frame_end) begin
                        state <= rtu_frame_pkg::ST_CHECK;
                    end
                end
                rtu_frame_pkg::ST_CHECK: begin
                    frame_bc   <= bcast;
                    is_read    <= func == rtu_frame_pkg::FN_READ;
                    start_addr <= {mem[rtu_frame_pkg::OFS_START], mem[rtu_frame_pkg::OFS_START+1]};
                    idx        <= '0;
                    phase      <= 2'd0;
                    elem       <= func == rtu_frame_pkg::FN_WRITE_ONE ? IW'(1) : IW'(count_i);
                    data_ofs   <= func == rtu_frame_pkg::FN_WRITE_ONE ? IW'(rtu_frame_pkg::OFS_WDATA_1)
                                                                      : IW'(rtu_frame_pkg::OFS_WDATA_N);
                    if (drop || (bcast && chk_err != 8'h00)) begin
                        state <= rtu_frame_pkg::ST_RX;
                    end else if (chk_err != 8'h00) begin
                        reply_len <= IW'(rtu_frame_pkg::REPLY_ERR);
                        state     <= rtu_frame_pkg::ST_DELAY;
                    end else if (func == rtu_frame_pkg::FN_ECHO) begin
                        reply_len <= rx_len - IW'(rtu_frame_pkg::CRC_LEN);
                        state     <= rtu_frame_pkg::ST_DELAY;
                    end else begin
                        reply_len <= func == rtu_frame_pkg::FN_READ
                                   ? IW'(rtu_frame_pkg::REPLY_ERR + 2 * count_i)
                                   : IW'(rtu_frame_pkg::REPLY_WRITE);
                        state     <= rtu_frame_pkg::ST_EXEC;
                    end
                end
                rtu_frame_pkg::ST_EXEC: begin
                    case (phase)
                        2'd0: begin
                            o_var_addr  <= start_addr + 16'(idx);
                            o_wr_data   <= {mem[data_ofs + {idx[IW-2:0], 1'b0}],
                                            mem[data_ofs + {idx[IW-2:0], 1'b0} + 1'b1]};
                            o_rd_strobe <= is_read;
                            o_wr_strobe <= !is_read;
                            phase       <= 2'd1;
                        end
                        2'd1: begin
                            o_rd_strobe <= 1'b0;
                            o_wr_strobe <= 1'b0;
                            phase       <= 2'd2;
                        end
                        default: begin
                            phase <= 2'd0;
                            idx   <= idx + 1'b1;
                            if (svc_err != 8'h00) begin
                                reply_len <= IW'(rtu_frame_pkg::REPLY_ERR);
                                state     <= frame_bc ? rtu_frame_pkg::ST_RX : rtu_frame_pkg::ST_DELAY;
                            end else if (last_elem) begin
                                state <= frame_bc ? rtu_frame_pkg::ST_RX : rtu_frame_pkg::ST_DELAY;
                            end
                        end
                    endcase
                end
                rtu_frame_pkg::ST_DELAY: begin
                    idx <= '0;
                    if (ms_left == 7'h00) begin
                        state <= rtu_frame_pkg::ST_SEND;
                    end
                end
                rtu_frame_pkg::ST_SEND: begin
                    // One idle cycle per byte keeps the data output registered
                    if (!o_tx_valid) begin
                        o_tx_valid <= 1'b1;
                        if (idx < reply_len) begin
                            o_tx_data <= mem[idx];
                        end else if (idx == reply_len) begin
                            o_tx_data <= crc[7:0];
                        end else begin
                            o_tx_data <= crc[15:8];
                        end
                    end else if (tx_fire) begin
                        o_tx_valid <= 1'b0;
                        idx        <= idx + 1'b1;
                        if (idx == reply_len + 1'b1) begin
                            state <= rtu_frame_pkg::ST_RX;
                        end
                    end
                end
                default: state <= rtu_frame_pkg::ST_RX;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_bcast_silent: assert property (
        @(posedge i_clock) disable iff (i_srst)
        ((state == rtu_frame_pkg::ST_CHECK && bcast) || (state == rtu_frame_pkg::ST_EXEC && frame_bc))
        |=> state != rtu_frame_pkg::ST_DELAY)
        else $error("reply traffic after broadcast");

    a_drop_foreign: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_CHECK && !bcast && mem[0] != {2'b00, i_unit_number})
        |=> state == rtu_frame_pkg::ST_RX)
        else $error("foreign address not discarded");

    a_drop_fault: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_CHECK && rx_bad) |=> state == rtu_frame_pkg::ST_RX)
        else $error("faulty character frame not dropped");

    a_drop_crc: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_CHECK && crc != 16'h0000) |=> state == rtu_frame_pkg::ST_RX)
        else $error("bad check value not dropped");

    a_crc_seed: assert property (
        @(posedge i_clock) disable iff (i_srst)
        $rose(state == rtu_frame_pkg::ST_SEND) |-> crc == rtu_frame_pkg::CRC_INIT)
        else $error("send check value not seeded");

    a_err_func: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_CHECK && !drop && chk_err != 8'h00)
        |=> mem[1] == ($past(mem[1]) | rtu_frame_pkg::FN_ERROR_FLAG) && mem[2] == $past(chk_err))
        else $error("error reply code wrong");

    a_delay_hold: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_DELAY && ms_left != 7'h00) |=> state == rtu_frame_pkg::ST_DELAY)
        else $error("send delay cut short");

    a_crc_low_first: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (o_tx_valid && state == rtu_frame_pkg::ST_SEND && idx == reply_len) |-> o_tx_data == crc[7:0])
        else $error("check bytes out of order");

    a_frame_gap: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (state == rtu_frame_pkg::ST_RX ##1 state == rtu_frame_pkg::ST_CHECK)
        |-> $past(silence_cnt) == SW'(SILENCE_CYCLES - 1))
        else $error("frame closed without silence");

endmodule

// [host_link_model.sv]
// Purpose: Host end of the serial link: sends command bytes, collects reply bytes.
// Assumes: Byte-level link; a reply byte is taken on valid and ready.
// Notes:   Ready stalls at random so that reply bytes must hold.
`timescale 1ns/1ps
module host_link_model (
    input  wire logic       i_clock,
    output logic            o_rx_valid = 1'b0,
    output logic      [7:0] o_rx_data = 8'h00,
    output logic            o_rx_error = 1'b0,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready = 1'b0
);
    logic [7:0] rxq[$];

    // ==========================================================
    // Reply collection
    always @(posedge i_clock) begin
        if (i_tx_valid && o_tx_ready) begin
            rxq.push_back(i_tx_data);
        end
        #1 o_tx_ready = 1'($urandom_range(0, 1));
    end

    // ==========================================================
    // Command frame; address 0..63 and counts come from the caller
    task automatic send(input logic [7:0] b[$], input int gap_at, input int err_at);
        foreach (b[k]) begin
            @(posedge i_clock);
            #1 o_rx_valid = 1'b1;
            o_rx_data = b[k];
            o_rx_error = (k == err_at);
            @(posedge i_clock);
            // Released line shows the inverse, never a stale copy
            #1 o_rx_valid = 1'b0;
            o_rx_data = ~b[k];
            o_rx_error = 1'b0;
            repeat ((k == gap_at) ? 45 : $urandom_range(0, 3)) @(posedge i_clock);
        end
    endtask
endmodule

// [tb_rtu_slave_frame_handler.sv]
// Purpose: Self-checking bench for the serial slave frame handler.
// Assumes: Silence 40 cycles, 10 cycles per ms; service answers from the held address.
// Notes:   Replies and check values are computed here on their own.
`timescale 1ns/1ps
module tb_rtu_slave_frame_handler;
    localparam int          SIL = 40;
    localparam logic [15:0] KEY = 16'h5a3c;
    localparam logic [15:0] BAD = 16'h0bad;
    logic        i_clock = 1'b0, i_srst = 1'b1, rx_valid, rx_error, tx_ready, tx_valid, rd_strobe, wr_strobe;
    logic [5:0]  i_unit_number = 6'h01;
    logic [6:0]  i_send_delay_ms = 7'h00;
    logic [7:0]  rx_data, tx_data, u, f[$], e[$];
    logic [15:0] var_addr, wr_data, a, v;
    int          mismatches = 0, total_checks = 0, n_rd = 0, n_wr = 0, n0;
    int          cn[3] = '{0, 80, 81};
    wire  [15:0] rd_data = var_addr ^ KEY;
    wire  [7:0]  svc_err = (var_addr == BAD) ? 8'h02 : 8'h00;

    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        n_rd += int'(rd_strobe);
        n_wr += int'(wr_strobe);
    end

    rtu_slave_frame_handler #(.SILENCE_CYCLES(SIL), .MS_CYCLES(10)) i_rtu_slave_frame_handler (
        .i_clock(i_clock), .i_srst(i_srst), .i_unit_number(i_unit_number), .i_send_delay_ms(i_send_delay_ms),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_error(rx_error), .i_tx_ready(tx_ready),
        .i_rd_data(rd_data), .i_rd_error(svc_err), .i_wr_error(svc_err), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .o_rd_strobe(rd_strobe), .o_wr_strobe(wr_strobe), .o_var_addr(var_addr),
        .o_wr_data(wr_data));
    host_link_model i_host_link_model (.i_clock(i_clock), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rx_error(rx_error), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));

    // ==========================================================
    // Checking helpers
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[k]) begin
            c ^= {8'h00, q[k]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic cmp(input string s, input logic [15:0] x, input logic [15:0] y);
        total_checks++;
        if (y !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", s, x, y);
        end
    endtask
    task automatic cmp8(input string s, input logic [7:0] x, input logic [7:0] y);
        cmp(s, {8'h00, x}, {8'h00, y});
    endtask
    task automatic addc(inout logic [7:0] q[$]);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask
    task automatic er(input logic [7:0] fc, input logic [7:0] code);
        e = {u, fc | 8'h80, code};
        addc(e);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Send f, then expect exactly e back (empty means silence)
    task automatic xfer(input int gap_at, input int err_at);
        int t;
        logic [7:0] r[$];
        #1 i_send_delay_ms = 7'($urandom_range(0, 2));
        i_host_link_model.rxq.delete();
        i_host_link_model.send(f, gap_at, err_at);
        for (t = 0; t < 3000; t++) begin
            @(posedge i_clock);
            if (e.size() != 0 && i_host_link_model.rxq.size() >= e.size()) break;
        end
        if (e.size() != 0 && t == 3000) begin
            mismatches++;
            conclude();
        end
        repeat (SIL + 20) @(posedge i_clock);
        r = i_host_link_model.rxq;
        cmp("reply length", 16'(e.size()), 16'(r.size()));
        foreach (e[k]) if (k < r.size()) cmp8("reply byte", e[k], r[k]);
    endtask
    task automatic rd(input logic [15:0] ad, input logic [15:0] cnt);
        f = {u, 8'h03, ad[15:8], ad[7:0], cnt[15:8], cnt[7:0]};
        addc(f);
        e = {u, 8'h03, 8'(2 * cnt)};
        for (int k = 0; k < cnt; k++) begin
            v = (ad + 16'(k)) ^ KEY;
            e.push_back(v[15:8]);
            e.push_back(v[7:0]);
        end
        addc(e);
        if (cnt == 0 || cnt > 80 || ad == BAD) er(8'h03, (ad == BAD) ? 8'h02 : 8'h03);
        n0 = n_rd;
        xfer(-1, -1);
        cmp("read strobes", (cnt == 0 || cnt > 80) ? 16'h0000 : cnt, 16'(n_rd - n0));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h14c9_9e67));
        u = 8'h01;
        repeat (20) @(posedge i_clock);
        #1 i_srst = 1'b0;
        repeat (SIL + 20) @(posedge i_clock);
        cmp("check sample", 16'hb285, crc16('{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h01}));
        rd(16'h0200, 16'h0001);
        u = 8'($urandom_range(2, 63));
        #1 i_unit_number = u[5:0];
        repeat (3) rd(16'h1000 + 16'($urandom_range(0, 255)), 16'($urandom_range(1, 4)));
        foreach (cn[i]) rd(16'h1100, 16'(cn[i]));
        rd(BAD, 16'h0001);
        a = 16'h2000 + 16'($urandom_range(0, 255));
        v = 16'($urandom);
        f = {u, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
        addc(f);
        e = f;
        xfer(-1, -1);
        cmp("write address", a, var_addr);
        cmp("write data", v, wr_data);
        f = {u, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], ~v[15:8], ~v[7:0]};
        e = f[0:5];
        addc(f);
        addc(e);
        n0 = n_wr;
        xfer(-1, -1);
        cmp("write strobes", 16'h0002, 16'(n_wr - n0));
        cmp("last write data", ~v, wr_data);
        f = {u, 8'h08, 8'h00, 8'h00, 8'($urandom), 8'($urandom)};
        addc(f);
        e = f;
        xfer(-1, -1);
        f = {u, 8'h06, BAD[15:8], BAD[7:0], v[15:8], v[7:0]};
        addc(f);
        er(8'h06, 8'h02);
        xfer(-1, -1);
        f = {u, 8'h41, 8'h00, 8'h00, 8'h00, 8'h01};
        addc(f);
        er(8'h41, 8'h01);
        xfer(-1, -1);
        for (int c = 0; c < 5; c++) begin
            f = {(c == 0) ? 8'(u % 63 + 1) : (c == 1) ? 8'h00 : u, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01};
            addc(f);
            if (c == 2) f[7] = ~f[7];
            e = {};
            n0 = n_rd;
            xfer((c == 3) ? 3 : -1, (c == 4) ? 2 : -1);
            cmp("read strobes", 16'h0000, 16'(n_rd - n0));
        end
        f = {8'h00, 8'h06, a[15:8], a[7:0], v[7:0], v[15:8]};
        addc(f);
        n0 = n_wr;
        xfer(-1, -1);
        cmp("broadcast writes", 16'h0001, 16'(n_wr - n0));
        cmp("broadcast data", {v[7:0], v[15:8]}, wr_data);
        conclude();
    end
endmodule
